// ---- src/tpp_core.v ----
// Two-phase PWM timing, current balance, soft-start and overcurrent sequencing
`include "tpp_defines.vh"
module tpp_core #(
	parameter DW = 8,
	parameter SSW = 12,
	parameter PERIOD = `TPP_SW_PERIOD_NS / `TPP_CLK_PERIOD_NS,
	parameter RATE_DIV = `TPP_SS_TICK_NS / `TPP_CLK_PERIOD_NS,
	parameter [SSW-1:0] UP_STEP = `TPP_SS_UP_STEP,
	parameter [SSW-1:0] FAST_STEP = `TPP_SS_FAST_STEP,
	parameter [SSW-1:0] SLOW_STEP = `TPP_SS_SLOW_STEP
) (
	input wire clock,
	input wire resetn,
	input wire clk_en,
	input wire enable_in,
	input wire bias_ok,
	input wire reference_monitor_input,
	input wire [DW-1:0] error_level,
	input wire [DW-1:0] channel_current_input_a,
	input wire [DW-1:0] channel_current_input_b,
	input wire [DW-1:0] oc_reference,
	input wire output_in_window,
	output wire high_side_drive_a,
	output wire low_side_drive_a,
	output wire high_side_drive_b,
	output wire low_side_drive_b,
	output wire [SSW-1:0] soft_start_level,
	output wire [SSW-1:0] regulation_reference,
	output wire overcurrent_event,
	output wire oc_latched,
	output wire internal_ref_mode,
	output wire output_good_flag
);
	localparam integer LAST = PERIOD - 1;
	localparam integer HALF = PERIOD / 2;
	localparam integer PER_W = PERIOD;
	localparam integer DIV_LAST = RATE_DIV - 1;
	localparam [SSW-1:0] SS_TOP = `TPP_SS_TOP;
	localparam [SSW-1:0] SS_DRIVE_MIN = `TPP_SS_DRIVE_MIN;
	localparam [SSW-1:0] SS_REF_OFFSET = `TPP_SS_REF_OFFSET;
	localparam [2:0] OC_CONSEC = `TPP_OC_CONSEC;
	localparam [2:0] SS_OFF = 3'h0;
	localparam [2:0] SS_RAMP = 3'h1;
	localparam [2:0] SS_RUN = 3'h2;
	localparam [2:0] SS_OCDIS = 3'h3;
	localparam [2:0] SS_DORM_UP = 3'h4;
	localparam [2:0] SS_DORM_DN = 3'h5;
	localparam [2:0] SS_LATCH = 3'h6;

	reg [DW-1:0] cnt_r;
	reg [15:0] div_r;
	reg tick_r;
	reg [DW-1:0] samp_a_r;
	reg [DW-1:0] samp_b_r;
	reg [2:0] over_a_r;
	reg [2:0] over_b_r;
	reg [2:0] ss_state_r;
	reg [2:0] ss_state_nxt;
	reg [SSW-1:0] ss_r;
	reg [SSW-1:0] ss_nxt;
	reg [1:0] dorm_r;
	reg [1:0] dorm_nxt;
	reg en_q_r;
	reg mode_int_r;
	reg oc_evt_r;
	reg [SSW-1:0] ref_r;
	reg pg_r;

	wire enabled;
	wire running;
	wire allow;
	wire [DW:0] pos_b_sum;
	wire [DW:0] pos_b_wrap;
	wire [DW-1:0] pos_b;
	wire start_a;
	wire start_b;
	wire win_a;
	wire win_b;
	wire [DW:0] cur_sum;
	wire [DW-1:0] cur_avg;
	wire [DW+1:0] adj_a;
	wire [DW+1:0] adj_b;
	wire [DW-1:0] thr_a;
	wire [DW-1:0] thr_b;
	wire avg_over;
	wire hit_a;
	wire hit_b;
	wire oc_trig;
	wire [SSW:0] ss_up_sum;
	wire [SSW-1:0] ss_up;
	wire [SSW-1:0] ss_fast;
	wire [SSW-1:0] ss_slow;

	// all comparisons are digital and synchronous
	assign enabled = enable_in & bias_ok;
	assign running = (ss_state_r == SS_RAMP) || (ss_state_r == SS_RUN);
	// drives held off at low ramp
	assign allow = running && (ss_r >= SS_DRIVE_MIN) && !oc_trig;

	// phase b runs half a cycle behind phase a
	assign pos_b_sum = {1'b0, cnt_r} + HALF[DW:0];
	assign pos_b_wrap = (pos_b_sum >= PER_W[DW:0]) ? (pos_b_sum - PER_W[DW:0]) : pos_b_sum;
	assign pos_b = pos_b_wrap[DW-1:0];
	assign start_a = (cnt_r == {DW{1'b0}});
	assign start_b = (pos_b == {DW{1'b0}});

	always @(posedge clock) begin
		if (!resetn) begin
			cnt_r <= {DW{1'b0}};
		end else if (clk_en) begin
			if (cnt_r == LAST[DW-1:0]) begin
				cnt_r <= {DW{1'b0}};
			end else begin
				cnt_r <= cnt_r + {{(DW-1){1'b0}}, 1'b1};
			end
		end
	end

	assign cur_sum = {1'b0, samp_a_r} + {1'b0, samp_b_r};
	assign cur_avg = cur_sum[DW:1];
	assign adj_a = {2'b00, error_level} + {2'b00, cur_avg} - {2'b00, samp_a_r};
	assign adj_b = {2'b00, error_level} + {2'b00, cur_avg} - {2'b00, samp_b_r};
	// Saturate rather than wrap so a big imbalance cannot flip the duty
	assign thr_a = adj_a[DW+1] ? {DW{1'b0}} : (adj_a[DW] ? {DW{1'b1}} : adj_a[DW-1:0]);
	assign thr_b = adj_b[DW+1] ? {DW{1'b0}} : (adj_b[DW] ? {DW{1'b1}} : adj_b[DW-1:0]);

	tpp_phase #(
		.DW(DW),
		.PERIOD(PERIOD)
	) u_phase_a (
		.clock(clock),
		.resetn(resetn),
		.clk_en(clk_en),
		.allow(allow),
		.pos(cnt_r),
		.threshold(thr_a),
		.high_side_drive(high_side_drive_a),
		.low_side_drive(low_side_drive_a),
		.sample_window(win_a)
	);

	tpp_phase #(
		.DW(DW),
		.PERIOD(PERIOD)
	) u_phase_b (
		.clock(clock),
		.resetn(resetn),
		.clk_en(clk_en),
		.allow(allow),
		.pos(pos_b),
		.threshold(thr_b),
		.high_side_drive(high_side_drive_b),
		.low_side_drive(low_side_drive_b),
		.sample_window(win_b)
	);

	// hold last value seen in window
	always @(posedge clock) begin
		if (!resetn) begin
			samp_a_r <= {DW{1'b0}};
			samp_b_r <= {DW{1'b0}};
		end else if (clk_en) begin
			if (win_a) begin
				samp_a_r <= channel_current_input_a;
			end
			if (win_b) begin
				samp_b_r <= channel_current_input_b;
			end
		end
	end

	assign avg_over = running && (cur_avg > oc_reference);
	assign hit_a = running && start_a && (samp_a_r > oc_reference) && (over_a_r == OC_CONSEC - 3'h1);
	assign hit_b = running && start_b && (samp_b_r > oc_reference) && (over_b_r == OC_CONSEC - 3'h1);
	assign oc_trig = avg_over | hit_a | hit_b;

	always @(posedge clock) begin
		if (!resetn) begin
			over_a_r <= 3'h0;
			over_b_r <= 3'h0;
		end else if (clk_en) begin
			if (!running || oc_trig) begin
				over_a_r <= 3'h0;
				over_b_r <= 3'h0;
			end else begin
				if (start_a) begin
					over_a_r <= (samp_a_r > oc_reference) ? over_a_r + 3'h1 : 3'h0;
				end
				if (start_b) begin
					over_b_r <= (samp_b_r > oc_reference) ? over_b_r + 3'h1 : 3'h0;
				end
			end
		end
	end

	assign ss_up_sum = {1'b0, ss_r} + {1'b0, UP_STEP};
	assign ss_up = (ss_up_sum >= {1'b0, SS_TOP}) ? SS_TOP : ss_up_sum[SSW-1:0];
	assign ss_fast = (ss_r > FAST_STEP) ? ss_r - FAST_STEP : {SSW{1'b0}};
	assign ss_slow = (ss_r > SLOW_STEP) ? ss_r - SLOW_STEP : {SSW{1'b0}};

	always @(posedge clock) begin
		if (!resetn) begin
			div_r <= 16'h0000;
			tick_r <= 1'b0;
		end else if (clk_en) begin
			if (div_r == DIV_LAST[15:0]) begin
				div_r <= 16'h0000;
				tick_r <= 1'b1;
			end else begin
				div_r <= div_r + 16'h0001;
				tick_r <= 1'b0;
			end
		end
	end

	always @* begin
		ss_state_nxt = ss_state_r;
		ss_nxt = ss_r;
		dorm_nxt = dorm_r;
		if (!enabled) begin
			ss_state_nxt = SS_OFF;
			if (tick_r) begin
				ss_nxt = ss_fast;
			end
		end else begin
			case (ss_state_r)
			SS_OFF: begin
				if (tick_r) begin
					ss_nxt = ss_fast;
				end
				if (ss_r == {SSW{1'b0}}) begin
					ss_state_nxt = SS_RAMP;
				end
			end
			SS_RAMP, SS_RUN: begin
				if (oc_trig) begin
					dorm_nxt = 2'h0;
					ss_state_nxt = mode_int_r ? SS_OCDIS : SS_LATCH;
				end else begin
					if (tick_r) begin
						ss_nxt = ss_up;
					end
					if (ss_r == SS_TOP) begin
						ss_state_nxt = SS_RUN;
					end
				end
			end
			SS_OCDIS: begin
				if (tick_r) begin
					ss_nxt = ss_slow;
				end
				if (ss_r == {SSW{1'b0}}) begin
					ss_state_nxt = SS_DORM_UP;
				end
			end
			SS_DORM_UP: begin
				if (tick_r) begin
					ss_nxt = ss_up;
				end
				if (ss_r == SS_TOP) begin
					ss_state_nxt = SS_DORM_DN;
				end
			end
			SS_DORM_DN: begin
				if (tick_r) begin
					ss_nxt = ss_slow;
				end
				if (ss_r == {SSW{1'b0}}) begin
					// restart attempt, repeats on new event
					if (dorm_r == `TPP_DORMANT_LAST) begin
						ss_state_nxt = SS_RAMP;
					end else begin
						dorm_nxt = dorm_r + 2'h1;
						ss_state_nxt = SS_DORM_UP;
					end
				end
			end
			SS_LATCH: begin
				if (tick_r) begin
					ss_nxt = ss_slow;
				end
			end
			default: begin
				ss_state_nxt = SS_OFF;
			end
			endcase
		end
	end

	always @(posedge clock) begin
		if (!resetn) begin
			ss_state_r <= SS_OFF;
			ss_r <= {SSW{1'b0}};
			dorm_r <= 2'h0;
			en_q_r <= 1'b0;
			mode_int_r <= 1'b0;
			oc_evt_r <= 1'b0;
			ref_r <= {SSW{1'b0}};
			pg_r <= 1'b0;
		end else if (clk_en) begin
			ss_state_r <= ss_state_nxt;
			ss_r <= ss_nxt;
			dorm_r <= dorm_nxt;
			en_q_r <= enabled;
			if (enabled && !en_q_r) begin
				mode_int_r <= reference_monitor_input;
			end
			oc_evt_r <= oc_trig;
			ref_r <= (ss_r > SS_REF_OFFSET) ? ss_r - SS_REF_OFFSET : {SSW{1'b0}};
			pg_r <= enabled && running && output_in_window && !oc_trig;
		end
	end

	assign soft_start_level = ss_r;
	assign regulation_reference = ref_r;
	assign overcurrent_event = oc_evt_r;
	assign oc_latched = (ss_state_r == SS_LATCH);
	assign internal_ref_mode = mode_int_r;
	assign output_good_flag = pg_r;
endmodule // tpp_core

// ---- src/tpp_defines.vh ----
// Shared constants for the two-phase PWM sequencer
// Functional notes
// - Cycle starts as clock ends one high drive; other phase ends half cycle later.
// - Low drive stays on at least one third cycle after high drive ends.
// - After forced low time, high drive starts when sawtooth crosses adjusted error.
// - Low drive drops one clock before high drive rises; never both on.
// - High drive stays on until next cycle start for that phase.
// - Channel current is sampled only while that phase's low drive is on.
// - Above-average channel gets shorter pulse, below-average longer, cancelling imbalance.
// - Soft-start ramp rises linearly from zero once fully enabled.
// - Reference follows ramp one-to-one above 0.7 V offset, else zero.
// - Power loss or disable discharges the ramp with the fast step.
// - Average current above overcurrent reference raises an overcurrent event at once.
// - One channel above reference seven cycles running raises an event; dips restart.
// - Overcurrent turns all drives off and discharges ramp with slow step.
// - Monitor input above 3.5 V selects internal-reference mode, else external.
// - Internal mode runs two dormant ramp cycles, drives off, then restarts.
// - Internal mode repeats discharge, dormant cycles, restart on every new event.
// - External mode latches off with all drives off, ramp discharged to zero.
// - Latch clears only by bias loss or enable toggle; outside must toggle enable.
// - Once latch clears, a fresh soft-start cycle restores the output.
// - Hiccup waits until ramp reaches zero; otherwise the sequence stalls.
// - Reference mode is captured at each enable or bias release, then held.
// - All gate drives stay off while ramp is below 0.3 V.
// - Power-good is forced low on overcurrent, disable or bias loss.
`ifndef TPP_DEFINES_VH
`define TPP_DEFINES_VH
`define TPP_CLK_PERIOD_NS 10
`define TPP_SW_PERIOD_NS 1000
`define TPP_SS_TICK_NS 1000
`define TPP_SS_DRIVE_MIN 12'h12c
`define TPP_SS_REF_OFFSET 12'h2bc
`define TPP_SS_TOP 12'hdac
`define TPP_SS_UP_STEP 12'h001
`define TPP_SS_FAST_STEP 12'h064
`define TPP_SS_SLOW_STEP 12'h002
`define TPP_OC_CONSEC 3'h7
`define TPP_DORMANT_LAST 2'h1
`define TPP_PH_IDLE 3'h0
`define TPP_PH_LOW 3'h1
`define TPP_PH_ARM 3'h2
`define TPP_PH_DEAD 3'h3
`define TPP_PH_HIGH 3'h4
`endif

// ---- src/tpp_phase.v ----
// One phase of gate drive timing
`include "tpp_defines.vh"
module tpp_phase #(
	parameter DW = 8,
	parameter PERIOD = 100
) (
	input wire clock,
	input wire resetn,
	input wire clk_en,
	input wire allow,
	input wire [DW-1:0] pos,
	input wire [DW-1:0] threshold,
	output wire high_side_drive,
	output wire low_side_drive,
	output wire sample_window
);
	localparam integer LAST = PERIOD - 1;
	// Rounded up so the forced low time is never short
	localparam integer THIRD = (PERIOD + 2) / 3;
	localparam [2:0] ST_IDLE = `TPP_PH_IDLE;
	localparam [2:0] ST_LOW = `TPP_PH_LOW;
	localparam [2:0] ST_ARM = `TPP_PH_ARM;
	localparam [2:0] ST_DEAD = `TPP_PH_DEAD;
	localparam [2:0] ST_HIGH = `TPP_PH_HIGH;
	reg [2:0] state_r;
	reg hi_r;
	reg lo_r;
	wire cyc_start;
	wire [DW-1:0] saw;
	assign cyc_start = (pos == {DW{1'b0}});
	// Falling sawtooth so a larger error gives a wider pulse
	assign saw = LAST[DW-1:0] - pos;
	assign high_side_drive = hi_r;
	assign low_side_drive = lo_r;
	assign sample_window = lo_r;
	always @(posedge clock) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			hi_r <= 1'b0;
			lo_r <= 1'b0;
		end else if (clk_en) begin
			if (!allow) begin
				state_r <= ST_IDLE;
				hi_r <= 1'b0;
				lo_r <= 1'b0;
			end else begin
				case (state_r)
				ST_IDLE: begin
					if (cyc_start) begin
						state_r <= ST_LOW;
						lo_r <= 1'b1;
					end
				end
				ST_LOW: begin
					if (!cyc_start && pos >= THIRD[DW-1:0]) begin
						state_r <= ST_ARM;
					end
				end
				ST_ARM: begin
					if (cyc_start) begin
						state_r <= ST_LOW;
					end else if (saw < threshold) begin
						state_r <= ST_DEAD;
						lo_r <= 1'b0;
					end
				end
				ST_DEAD: begin
					if (cyc_start) begin
						state_r <= ST_LOW;
						lo_r <= 1'b1;
					end else begin
						state_r <= ST_HIGH;
						hi_r <= 1'b1;
					end
				end
				ST_HIGH: begin
					if (cyc_start) begin
						state_r <= ST_LOW;
						hi_r <= 1'b0;
						lo_r <= 1'b1;
					end
				end
				default: begin
					state_r <= ST_IDLE;
					hi_r <= 1'b0;
					lo_r <= 1'b0;
				end
				endcase
			end
		end
	end
endmodule // tpp_phase

// ---- testbench/tpp_core_props.sv ----
// Port checks for the two-phase PWM sequencer
module tpp_core_props #(
	parameter SSW = 12,
	parameter PERIOD = 100
) (
	input wire clock,
	input wire resetn,
	input wire enable_in,
	input wire bias_ok,
	input wire high_side_drive_a,
	input wire low_side_drive_a,
	input wire high_side_drive_b,
	input wire low_side_drive_b,
	input wire [SSW-1:0] soft_start_level,
	input wire [SSW-1:0] regulation_reference,
	input wire overcurrent_event,
	input wire internal_ref_mode,
	input wire output_good_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	wire any_drive = high_side_drive_a | low_side_drive_a | high_side_drive_b | low_side_drive_b;
	reg [15:0] low_run_r;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);
	// Low drive run length
	always @(posedge clock) begin
		if (!resetn || !low_side_drive_a)
			low_run_r <= 16'h0000;
		else
			low_run_r <= low_run_r + 16'h0001;
	end
	property p_excl;
		!(high_side_drive_a && low_side_drive_a) && !(high_side_drive_b && low_side_drive_b);
	endproperty
	a_excl: assert property (p_excl) else $error("upper and lower drive overlap");
	property p_dead;
		$rose(high_side_drive_a) |-> !$past(low_side_drive_a) && $past(low_side_drive_a, 2);
	endproperty
	a_dead: assert property (p_dead) else $error("no dead clock before upper drive");
	// Faults and disable cut the low window short
	property p_min_low;
		disable iff (!resetn || !enable_in || !bias_ok || overcurrent_event)
		$fell(low_side_drive_a) |-> low_run_r >= (PERIOD + 2) / 3;
	endproperty
	a_min_low: assert property (p_min_low) else $error("low window too short");
	property p_floor;
		soft_start_level < 12'h12c |-> !any_drive;
	endproperty
	a_floor: assert property (p_floor) else $error("drive while ramp low");
	property p_ref;
		1'b1 |=> regulation_reference ==
			($past(soft_start_level) > 12'h2bc ? $past(soft_start_level) - 12'h2bc : 12'h000);
	endproperty
	a_ref: assert property (p_ref) else $error("reference does not track ramp");
	property p_oc_off;
		overcurrent_event |-> !any_drive;
	endproperty
	a_oc_off: assert property (p_oc_off) else $error("drive during overcurrent");
	property p_pg_off;
		!enable_in ##1 !enable_in |=> !output_good_flag;
	endproperty
	a_pg_off: assert property (p_pg_off) else $error("power good while disabled");
	property p_mode_hold;
		enable_in && bias_ok && $past(enable_in) && $past(bias_ok) && $past(resetn) |=> $stable(internal_ref_mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed while enabled");
	c_oc: cover property (overcurrent_event);
	c_pulse_b: cover property ($rose(high_side_drive_b));
	c_top: cover property (soft_start_level == 12'hdac);
endmodule // tpp_core_props

bind tpp_core tpp_core_props #(.SSW(SSW), .PERIOD(PERIOD)) props_u (
	.clock(clock), .resetn(resetn), .enable_in(enable_in), .bias_ok(bias_ok),
	.high_side_drive_a(high_side_drive_a), .low_side_drive_a(low_side_drive_a),
	.high_side_drive_b(high_side_drive_b), .low_side_drive_b(low_side_drive_b),
	.soft_start_level(soft_start_level), .regulation_reference(regulation_reference),
	.overcurrent_event(overcurrent_event), .internal_ref_mode(internal_ref_mode),
	.output_good_flag(output_good_flag));

// ---- testbench/tpp_core_test.sv ----
// Self-checking bench for the two-phase PWM sequencer
module tpp_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 12;
	localparam int RD = 2;
	localparam [11:0] UP = 12'h014;
	localparam [11:0] FS = 12'h064;
	localparam [11:0] SL = 12'h014;
	localparam [11:0] TOP = 12'hdac;
	logic clock = 1'b0, resetn = 1'b0, enable_in = 1'b0, bias_ok = 1'b1, mon = 1'b1, ls_q = 1'b0;
	logic [7:0] err = 8'h04, lvl_a = 8'h20, lvl_b = 8'h20, ocr = 8'hf0;
	wire [7:0] cur_a, cur_b;
	wire hs_a, ls_a, hs_b, ls_b, ev, latched, mode, pg, shoot;
	wire [11:0] ss, rref;
	int n_mismatch = 0, tests_run = 0, starts = 0;
	tpp_core #(.PERIOD(P), .RATE_DIV(RD), .UP_STEP(UP), .FAST_STEP(FS), .SLOW_STEP(SL)) dut_u (
		.clock(clock), .resetn(resetn), .clk_en(1'b1), .enable_in(enable_in), .bias_ok(bias_ok),
		.reference_monitor_input(mon), .error_level(err), .channel_current_input_a(cur_a),
		.channel_current_input_b(cur_b), .oc_reference(ocr), .output_in_window(1'b1),
		.high_side_drive_a(hs_a), .low_side_drive_a(ls_a), .high_side_drive_b(hs_b),
		.low_side_drive_b(ls_b), .soft_start_level(ss), .regulation_reference(rref),
		.overcurrent_event(ev), .oc_latched(latched), .internal_ref_mode(mode), .output_good_flag(pg));
	tpp_gate_model gate_u (.clock(clock), .high_side_drive_a(hs_a), .low_side_drive_a(ls_a),
		.high_side_drive_b(hs_b), .low_side_drive_b(ls_b), .level_a(lvl_a), .level_b(lvl_b),
		.channel_current_input_a(cur_a), .channel_current_input_b(cur_b), .shoot_through(shoot));
	initial forever #5 clock = ~clock;
	// Cycle starts of phase a
	always @(posedge clock) begin
		ls_q <= ls_a;
		if (ls_a && !ls_q)
			starts <= starts + 1;
	end
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic final_report();
		$display("Checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic t_start();
		int i, n;
		logic [11:0] s0;
		chk("ramp_reset", 12'h000, ss);
		enable_in = 1'b1;
		cyc(3);
		s0 = ss;
		cyc(2 * RD);
		chk("ramp_rise", 12'(s0 + 2 * UP), ss);
		for (i = 0; i < 4000 && ss !== TOP; i++) cyc(1);
		cyc(2);
		chk("ref", TOP - 12'h2bc, rref);
		chk("mode_int", 12'h001, 12'(mode));
		for (i = 0; i < 50 && hs_a !== 1'b1; i++) cyc(1);
		for (i = 0; i < 50 && hs_a !== 1'b0; i++) cyc(1);
		for (n = 0; n < 50 && hs_b !== 1'b1; n++) cyc(1);
		for (; n < 50 && hs_b !== 1'b0; n++) cyc(1);
		chk("interleave", 12'(P / 2), 12'(n));
		chk("pg", 12'h001, 12'(pg));
	endtask
	// Crossings at pos 6 and pos 5, first check after the floor
	task automatic t_balance();
		int i, wa, wb;
		err = 8'h08;
		lvl_a = 8'h22;
		lvl_b = 8'h1e;
		cyc(3 * P);
		wa = 0;
		wb = 0;
		for (i = 0; i < 2 * P; i++) begin
			wa += int'(hs_a === 1'b1);
			wb += int'(hs_b === 1'b1);
			cyc(1);
		end
		chk("balance", 12'(wb - 2), 12'(wa));
	endtask
	task automatic t_oc_hiccup();
		int i, s, tops;
		logic zs;
		logic [11:0] s0, last;
		err = 8'h18;
		ocr = 8'h28;
		lvl_b = 8'h10;
		s = starts;
		for (i = 0; i < 50 && starts == s; i++) cyc(1);
		lvl_a = 8'h30;
		s = starts;
		for (i = 0; i < 20 * P && ev !== 1'b1; i++) cyc(1);
		// First over cycle had already begun, so six new starts
		chk("oc_cycles", 12'h006, 12'(starts - s));
		cyc(2);
		s0 = ss;
		cyc(2 * RD);
		chk("slow_step", 12'(s0 - 2 * SL), ss);
		tops = 0;
		zs = 1'b0;
		last = ss;
		for (i = 0; i < 20000 && hs_a !== 1'b1; i++) begin
			cyc(1);
			if (ss === TOP && last !== TOP)
				tops++;
			if (ss === 12'h000)
				zs = 1'b1;
			last = ss;
		end
		chk("zero_first", 12'h001, 12'(zs));
		chk("dormant", 12'h002, 12'(tops));
		for (i = 0; i < 10 * P && ev !== 1'b1; i++) cyc(1);
		chk("oc_again", 12'h001, 12'(ev));
		lvl_a = 8'h20;
		lvl_b = 8'h20;
		cyc(2);
		for (i = 0; i < 20000 && hs_a !== 1'b1; i++) cyc(1);
		for (i = 0; i < 4000 && ss !== TOP; i++) cyc(1);
		chk("recover", TOP, ss);
	endtask
	task automatic t_latch();
		int i;
		logic [11:0] s0;
		mon = 1'b0;
		bias_ok = 1'b0;
		cyc(3);
		s0 = ss;
		cyc(2 * RD);
		chk("fast_step", 12'(s0 - 2 * FS), ss);
		chk("pg_bias", 12'h000, 12'(pg));
		for (i = 0; i < 1000 && ss !== 12'h000; i++) cyc(1);
		bias_ok = 1'b1;
		cyc(2);
		mon = 1'b1;
		chk("mode_ext", 12'h000, 12'(mode));
		for (i = 0; i < 4000 && ss !== TOP; i++) cyc(1);
		chk("mode_held", 12'h000, 12'(mode));
		ocr = 8'h10;
		for (i = 0; i < 3 && ev !== 1'b1; i++) cyc(1);
		chk("oc_avg", 12'h001, 12'(ev));
		for (i = 0; i < 2000 && ss !== 12'h000; i++) cyc(1);
		chk("latched", 12'h001, 12'(latched));
		ocr = 8'hf0;
		cyc(200);
		chk("latch_hold", 12'h001, 12'(latched));
		chk("ramp_zero", 12'h000, ss);
		enable_in = 1'b0;
		cyc(2);
		enable_in = 1'b1;
		cyc(4 * RD);
		chk("latch_clr", 12'h000, 12'(latched));
		chk("mode_new", 12'h001, 12'(mode));
		chk("restart", 12'h001, 12'(ss > 12'h000));
	endtask
	initial begin
		cyc(5);
		resetn = 1'b1;
		cyc(1);
		t_start();
		t_balance();
		t_oc_hiccup();
		t_latch();
		chk("overlap", 12'h000, 12'(shoot));
		final_report();
	end
	// Whole run is some 5000 cycles
	initial begin
		#600us;
		n_mismatch++;
		final_report();
	end
endmodule // tpp_core_test

// ---- testbench/tpp_gate_model.sv ----
// Power stage stand-in: sensed current valid only while the lower switch conducts
module tpp_gate_model (
	input wire clock,
	input wire high_side_drive_a,
	input wire low_side_drive_a,
	input wire high_side_drive_b,
	input wire low_side_drive_b,
	input wire [7:0] level_a,
	input wire [7:0] level_b,
	output wire [7:0] channel_current_input_a,
	output wire [7:0] channel_current_input_b,
	output logic shoot_through
);
	timeunit 1ns;
	timeprecision 1ps;
	assign channel_current_input_a = low_side_drive_a ? level_a : ~level_a;
	assign channel_current_input_b = low_side_drive_b ? level_b : ~level_b;
	initial shoot_through = 1'b0;
	always @(posedge clock) begin
		if ((high_side_drive_a && low_side_drive_a) || (high_side_drive_b && low_side_drive_b))
			shoot_through <= 1'b1;
	end
endmodule // tpp_gate_model
